// [hw/fpctd_pkg.sv]
// package: constants and types shared by both ends of the fp transfer link
package fpctd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // instruction field positions
    localparam int FPCTD_POS_PRE   = 24;
    localparam int FPCTD_POS_UP    = 23;
    localparam int FPCTD_POS_LEN_H = 22;
    localparam int FPCTD_POS_WB    = 21;
    localparam int FPCTD_POS_LOAD  = 20;
    localparam int FPCTD_POS_RN    = 16;
    localparam int FPCTD_POS_LEN_L = 15;
    localparam int FPCTD_POS_FD    = 12;
    localparam int FPCTD_POS_CP    = 8;

    // coprocessor numbers and sizes
    localparam logic [3:0] FPCTD_CP_SINGLE = 4'h1;
    localparam logic [3:0] FPCTD_CP_GROUP  = 4'h2;
    localparam logic [3:0] FPCTD_PC_INDEX  = 4'hF;
    localparam logic [3:0] FPCTD_WORDS_REG = 4'h3;
    localparam logic [3:0] FPCTD_NW_SGL    = 4'h1;
    localparam logic [3:0] FPCTD_NW_DBL    = 4'h2;
    localparam logic [3:0] FPCTD_NW_EXT    = 4'h3;
    localparam logic [3:0] FPCTD_NW_EXPD   = 4'h4;
    localparam logic [31:0] FPCTD_WORD_STEP = 32'h4;

    // exponent rebias between internal and memory formats
    localparam logic [15:0] FPCTD_SGL_REBIAS = 16'h3F80;
    localparam logic [15:0] FPCTD_DBL_REBIAS = 16'h3C00;

    ////////////////////////////////////////////////////////////////////////
    // controller register map and bits
    localparam logic [7:0] FPCTD_REG_INSTR  = 8'h00;
    localparam logic [7:0] FPCTD_REG_BASE   = 8'h04;
    localparam logic [7:0] FPCTD_REG_CTRL   = 8'h08;
    localparam logic [7:0] FPCTD_REG_STATUS = 8'h0C;
    localparam logic [7:0] FPCTD_REG_NBASE  = 8'h10;
    localparam logic [7:0] FPCTD_REG_MADDR  = 8'h14;
    localparam logic [7:0] FPCTD_REG_MDATA  = 8'h18;
    localparam int FPCTD_CTRL_GO   = 0;
    localparam int FPCTD_CTRL_COND = 1;
    localparam int FPCTD_CTRL_EXPD = 2;
    localparam logic [31:0] FPCTD_RST_WORD = 32'h0;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        FPCTD_IDLE = 3'b001,
        FPCTD_XFER = 3'b010,
        FPCTD_DONE = 3'b100
    } fpctd_state_t;

    typedef enum logic [2:0] {
        FPCTD_LEN_SGL  = 3'h0,
        FPCTD_LEN_DBL  = 3'h1,
        FPCTD_LEN_EXT  = 3'h2,
        FPCTD_LEN_PKD  = 3'h3,
        FPCTD_LEN_EXPD = 3'h4,
        FPCTD_LEN_GRP  = 3'h5
    } fpctd_len_t;

endpackage

// [hw/fpctd_if.sv]
// interface: link between the transfer decoder and the issuing controller
`timescale 1ns/100ps
`default_nettype none
interface fpctd_if (
    input wire logic hclk,
    input wire logic hresetn
);
    logic        issue;
    logic [31:0] instr;
    logic [31:0] base;
    logic        cond_pass;
    logic        packed_format_flag;
    logic        busy;
    logic        done;
    logic        reject;
    logic        base_writeback;
    logic [31:0] new_base;
    logic        mem_req;
    logic        mem_wr;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic        mem_ack;
    logic [31:0] mem_rdata;

    modport device (
        input  hclk, hresetn, issue, instr, base, cond_pass, packed_format_flag,
        input  mem_ack, mem_rdata,
        output busy, done, reject, base_writeback, new_base,
        output mem_req, mem_wr, mem_addr, mem_wdata
    );
    modport host (
        input  hclk, hresetn, busy, done, reject, base_writeback, new_base,
        input  mem_req, mem_wr, mem_addr, mem_wdata,
        output issue, instr, base, cond_pass, packed_format_flag,
        output mem_ack, mem_rdata
    );
endinterface
`default_nettype wire

// [hw/fpctd_device.sv]
// device end: decodes fp transfer instructions and sequences their words
//
// Operation
// - store rounds to nearest, exact if precision suffices
// - offset byte counts are word count times four
// - up bit adds offset, down subtracts
// - pre-index offsets first address, post uses base
// - write-back bit returns modified base, else none
// - post-indexing never implies write-back
// - each following word one word higher
// - single form length from bits 22, 15, flag
// - software avoids deprecated packed decimal forms
// - group form moves one to four registers
// - group form moves three words per register
// - group save data reloaded only, never altered
// - coprocessor 2 means group, 1 single
// - group count 01,10,11,00 gives 1,2,3,4
// - group starts at named register, wraps F7->F0
// - pc base forbids write-back and post-indexing
// - assembler byte offsets multiple of four, bounded
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fpctd_device (
    // link to controller
    fpctd_if.device          link,
    // register inspection
    input  wire logic [2:0]  dbg_idx,
    output logic [79:0]      dbg_value
);
    import fpctd_pkg::*;

    fpctd_state_t state;
    fpctd_len_t   len_d, len_q;
    logic [3:0]   nw_d, nw_q, rcnt, k, cp_no;
    logic [2:0]   rcur, fd_d, nreg;
    logic [1:0]   wsub, lcode, idx, nidx;
    logic         load_q, grp_q, is_grp, cp_ok, start, step, last;
    logic [31:0]  addr, wdata, off_b, mod_d, first_d, c0, c1, c2;
    logic [79:0]  fregs [8];
    logic [31:0]  wbuf [4];

    ////////////////////////////////////////////////////////////////////////
    // format conversion
    // overflow and denormals are not handled; out of range exponents wrap
    function automatic logic [63:0] fp_round(input logic [79:0] r, input logic dbl);
        logic [53:0] m;
        logic        g, st;
        logic [15:0] e;
        m = dbl ? {1'b0, r[63:11]} : {30'h0, r[63:40]};
        g = dbl ? r[10] : r[39];
        st = dbl ? (|r[9:0]) : (|r[38:0]);
        e = {1'b0, r[78:64]} - (dbl ? FPCTD_DBL_REBIAS : FPCTD_SGL_REBIAS);
        m = m + {53'h0, g & (st | m[0])};
        if (dbl ? m[53] : m[24]) begin
            m = m >> 1;
            e = e + 16'h1;
        end
        if (r[63:0] == 64'h0) begin
            e = 16'h0;
        end
        fp_round = dbl ? {r[79], e[10:0], m[51:0]} : {32'h0, r[79], e[7:0], m[22:0]};
    endfunction

    function automatic logic [79:0] fp_unpack(input fpctd_len_t len, input logic [31:0] w0,
                                              input logic [31:0] w1, input logic [31:0] w2);
        logic [15:0] e;
        e = 16'h0;
        case (len)
            FPCTD_LEN_SGL: begin
                e = {8'h0, w0[30:23]} + FPCTD_SGL_REBIAS;
                fp_unpack = (w0[30:23] == 8'h0) ? {w0[31], 79'h0}
                                                : {w0[31], e[14:0], 1'b1, w0[22:0], 40'h0};
            end
            FPCTD_LEN_DBL: begin
                e = {5'h0, w0[30:20]} + FPCTD_DBL_REBIAS;
                fp_unpack = (w0[30:20] == 11'h0) ? {w0[31], 79'h0}
                                                 : {w0[31], e[14:0], 1'b1, w0[19:0], w1, 11'h0};
            end
            default: begin
                fp_unpack = {w0[31:16], w1, w2};
            end
        endcase
    endfunction

    // extended and group words carry the internal value unchanged
    function automatic logic [31:0] fp_word(input logic [79:0] r, input fpctd_len_t len,
                                            input logic [1:0] wi);
        logic [63:0] rd;
        rd = fp_round(r, len == FPCTD_LEN_DBL);
        case (len)
            FPCTD_LEN_SGL: fp_word = rd[31:0];
            FPCTD_LEN_DBL: fp_word = (wi == 2'h0) ? rd[63:32] : rd[31:0];
            default: begin
                case (wi)
                    2'h0:    fp_word = {r[79:64], 16'h0};
                    2'h1:    fp_word = r[63:32];
                    2'h2:    fp_word = r[31:0];
                    default: fp_word = 32'h0;
                endcase
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode
    assign lcode   = {link.instr[FPCTD_POS_LEN_H], link.instr[FPCTD_POS_LEN_L]};
    assign cp_no   = link.instr[FPCTD_POS_CP +: 4];
    assign is_grp  = (cp_no == FPCTD_CP_GROUP);
    assign cp_ok   = is_grp || (cp_no == FPCTD_CP_SINGLE);
    assign fd_d    = link.instr[FPCTD_POS_FD +: 3];
    assign off_b   = {22'h0, link.instr[7:0], 2'b00};
    assign mod_d   = link.instr[FPCTD_POS_UP] ? link.base + off_b
                                              : link.base - off_b;
    assign first_d = link.instr[FPCTD_POS_PRE] ? mod_d : link.base;
    assign start   = (state == FPCTD_IDLE) && link.issue && link.cond_pass && cp_ok;

    always_comb begin
        len_d = FPCTD_LEN_SGL;
        nw_d = FPCTD_NW_SGL;
        rcnt = 4'h4;
        if (is_grp) begin
            len_d = FPCTD_LEN_GRP;
            case (lcode)
                2'b01:   rcnt = 4'h1;
                2'b10:   rcnt = 4'h2;
                2'b11:   rcnt = 4'h3;
                default: rcnt = 4'h4;
            endcase
            nw_d = 4'(rcnt * FPCTD_WORDS_REG);
        end else begin
            case (lcode)
                2'b00:   nw_d = FPCTD_NW_SGL;
                2'b01: begin
                    len_d = FPCTD_LEN_DBL;
                    nw_d = FPCTD_NW_DBL;
                end
                2'b10: begin
                    len_d = FPCTD_LEN_EXT;
                    nw_d = FPCTD_NW_EXT;
                end
                default: begin
                    len_d = link.packed_format_flag ? FPCTD_LEN_EXPD : FPCTD_LEN_PKD;
                    nw_d = link.packed_format_flag ? FPCTD_NW_EXPD : FPCTD_NW_EXT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing
    assign step = (state == FPCTD_XFER) && link.mem_ack;
    assign last = (k == nw_q - 4'h1);
    assign idx  = grp_q ? wsub : k[1:0];
    assign nidx = grp_q ? ((wsub == 2'h2) ? 2'h0 : wsub + 2'h1) : k[1:0] + 2'h1;
    assign nreg = (grp_q && wsub == 2'h2) ? rcur + 3'h1 : rcur;

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            state <= FPCTD_IDLE;
        end else begin
            case (state)
                FPCTD_IDLE: begin
                    if (start) begin
                        state <= FPCTD_XFER;
                    end else if (link.issue) begin
                        state <= FPCTD_DONE;
                    end
                end
                FPCTD_XFER: state <= (step && last) ? FPCTD_DONE : FPCTD_XFER;
                FPCTD_DONE: state <= FPCTD_IDLE;
                default:    state <= FPCTD_IDLE;
            endcase
        end
    end

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            k <= 4'h0;
            wsub <= 2'h0;
            rcur <= 3'h0;
            addr <= FPCTD_RST_WORD;
            len_q <= FPCTD_LEN_SGL;
            nw_q <= FPCTD_NW_SGL;
            load_q <= 1'b0;
            grp_q <= 1'b0;
        end else if (start) begin
            k <= 4'h0;
            wsub <= 2'h0;
            rcur <= fd_d;
            addr <= first_d;
            len_q <= len_d;
            nw_q <= nw_d;
            load_q <= link.instr[FPCTD_POS_LOAD];
            grp_q <= is_grp;
        end else if (step) begin
            k <= k + 4'h1;
            addr <= addr + FPCTD_WORD_STEP;
            wsub <= grp_q ? nidx : 2'h0;
            rcur <= nreg;
        end
    end

    // write-back outcome stands until the next issue
    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            link.base_writeback <= 1'b0;
            link.new_base <= FPCTD_RST_WORD;
            link.reject <= 1'b0;
        end else if (state == FPCTD_IDLE && link.issue) begin
            link.base_writeback <= start && link.instr[FPCTD_POS_WB];
            link.new_base <= start ? mod_d : link.base;
            link.reject <= link.cond_pass && !cp_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data path
    // next store word is prepared a step ahead so it leaves a flop
    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            wdata <= FPCTD_RST_WORD;
        end else if (start) begin
            wdata <= fp_word(fregs[fd_d], len_d, 2'h0);
        end else if (step) begin
            wdata <= fp_word(fregs[nreg], len_q, nidx);
        end
    end

    assign c0 = (idx == 2'h0) ? link.mem_rdata : wbuf[0];
    assign c1 = (idx == 2'h1) ? link.mem_rdata : wbuf[1];
    assign c2 = (idx == 2'h2) ? link.mem_rdata : wbuf[2];

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            for (int i = 0; i < 8; i++) begin
                fregs[i] <= 80'h0;
            end
            for (int i = 0; i < 4; i++) begin
                wbuf[i] <= FPCTD_RST_WORD;
            end
        end else if (step && load_q) begin
            wbuf[idx] <= link.mem_rdata;
            if (grp_q ? (wsub == 2'h2) : last) begin
                fregs[rcur] <= fp_unpack(len_q, c0, c1, c2);
            end
        end
    end

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            dbg_value <= 80'h0;
        end else begin
            dbg_value <= fregs[dbg_idx];
        end
    end

    assign link.mem_req   = (state == FPCTD_XFER);
    assign link.mem_wr    = !load_q;
    assign link.mem_addr  = addr;
    assign link.mem_wdata = wdata;
    assign link.busy      = (state != FPCTD_IDLE);
    assign link.done      = (state == FPCTD_DONE);

endmodule
`default_nettype wire

// [hw/fpctd_host.sv]
// host end: ahb-lite controller that issues transfers and serves memory
`timescale 1ns/100ps
`default_nettype none
module fpctd_host #(
    parameter int DEPTH = 64
) (
    // link to device
    fpctd_if.host             link,
    // ahb-lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp
);
    import fpctd_pkg::*;
    localparam int AW = $clog2(DEPTH);

    logic          wr_q;
    logic [7:0]    a_q;
    logic [31:0]   instr;
    logic [31:0]   base;
    logic [AW-1:0] maddr;
    logic [5:0]    status;
    logic          ack;
    logic          go;
    logic          pc_bad;
    logic          dep;
    logic [31:0]   mem [DEPTH];
    logic [AW-1:0] didx;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            wr_q <= 1'b0;
            a_q <= 8'h0;
            hrdata <= FPCTD_RST_WORD;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            a_q <= haddr[7:0];
            case (haddr[7:0])
                FPCTD_REG_INSTR:  hrdata <= instr;
                FPCTD_REG_BASE:   hrdata <= base;
                FPCTD_REG_CTRL:   hrdata <= {29'h0, link.packed_format_flag, link.cond_pass, 1'b0};
                FPCTD_REG_STATUS: hrdata <= {26'h0, status[5:1], link.busy};
                FPCTD_REG_NBASE:  hrdata <= link.new_base;
                FPCTD_REG_MADDR:  hrdata <= 32'(maddr);
                FPCTD_REG_MDATA:  hrdata <= mem[maddr];
                default:          hrdata <= FPCTD_RST_WORD;
            endcase
        end
    end

    // offset field is taken as written: words only, eight bits
    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            instr <= FPCTD_RST_WORD;
            base <= FPCTD_RST_WORD;
            maddr <= '0;
            link.cond_pass <= 1'b0;
            link.packed_format_flag <= 1'b0;
        end else if (wr_q) begin
            case (a_q)
                FPCTD_REG_INSTR: instr <= hwdata;
                FPCTD_REG_BASE:  base <= hwdata;
                FPCTD_REG_MADDR: maddr <= hwdata[AW-1:0];
                FPCTD_REG_CTRL: begin
                    link.cond_pass <= hwdata[FPCTD_CTRL_COND];
                    link.packed_format_flag <= hwdata[FPCTD_CTRL_EXPD];
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // issue: pc base with write-back or post-indexing is refused here
    assign pc_bad = (instr[FPCTD_POS_RN +: 4] == FPCTD_PC_INDEX)
                    && (instr[FPCTD_POS_WB] || !instr[FPCTD_POS_PRE]);
    assign dep    = (instr[FPCTD_POS_CP +: 4] == FPCTD_CP_SINGLE)
                    && instr[FPCTD_POS_LEN_H] && instr[FPCTD_POS_LEN_L];
    assign go     = wr_q && (a_q == FPCTD_REG_CTRL) && hwdata[FPCTD_CTRL_GO] && !link.busy;

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            link.issue <= 1'b0;
            status <= 6'h0;
        end else begin
            link.issue <= go && !pc_bad;
            if (go) begin
                status <= {pc_bad, dep && !pc_bad, 3'h0, 1'b0};
            end
            if (link.done) begin
                status[3:1] <= {link.base_writeback, link.reject, 1'b1};
            end
        end
    end

    assign link.instr = instr;
    assign link.base  = base;

    ////////////////////////////////////////////////////////////////////////
    // memory: device store wins over a bus data write in the same cycle
    // group save words are stored and returned verbatim
    assign didx = link.mem_addr[AW+1:2];

    always_ff @(posedge link.hclk or negedge link.hresetn) begin
        if (!link.hresetn) begin
            ack <= 1'b0;
            link.mem_rdata <= FPCTD_RST_WORD;
        end else begin
            ack <= link.mem_req && !ack;
            if (link.mem_req && !ack) begin
                link.mem_rdata <= mem[didx];
            end
        end
    end

    always_ff @(posedge link.hclk) begin
        if (link.mem_req && !ack && link.mem_wr) begin
            mem[didx] <= link.mem_wdata;
        end else if (wr_q && a_q == FPCTD_REG_MDATA) begin
            mem[maddr] <= hwdata;
        end
    end

    assign link.mem_ack = ack;

endmodule
`default_nettype wire

// [testbench/fpctd_assertions.sv]
// checker: timing and result properties of the transfer link
`timescale 1ns/100ps
`default_nettype none
module fpctd_assertions (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // issue side
    input wire logic        issue,
    input wire logic [31:0] instr,
    input wire logic [31:0] base,
    input wire logic        cond_pass,
    input wire logic        packed_format_flag,
    // results
    input wire logic        busy,
    input wire logic        done,
    input wire logic        reject,
    input wire logic        base_writeback,
    input wire logic [31:0] new_base,
    // memory side
    input wire logic        mem_req,
    input wire logic        mem_wr,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack
);
    import fpctd_pkg::*;
    logic        take, cp_ok, exec, wb_q;
    logic [1:0]  y;
    logic [31:0] off, mod_base, first_addr, nb_q;
    logic [3:0]  nw, nw_q, ack_cnt;
    assign take = issue && !busy;
    assign cp_ok = instr[11:8] == FPCTD_CP_SINGLE || instr[11:8] == FPCTD_CP_GROUP;
    assign exec = cond_pass && cp_ok;
    assign off = {22'h0, instr[7:0], 2'b00};
    assign mod_base = instr[23] ? base + off : base - off;
    assign first_addr = instr[24] ? mod_base : base;
    assign y = {instr[22], instr[15]};
    // words per instruction; nw_q is zero when nothing executes
    assign nw = (instr[11:8] == FPCTD_CP_GROUP) ? 4'h3 * ((y == 2'h0) ? 4'h4 : {2'h0, y})
              : (y == 2'h3) ? (packed_format_flag ? 4'h4 : 4'h3) : {2'h0, y} + 4'h1;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nb_q <= 32'h0;
            wb_q <= 1'b0;
            nw_q <= 4'h0;
        end else if (take) begin
            nb_q <= exec ? mod_base : base;
            wb_q <= exec && instr[21];
            nw_q <= exec ? nw : 4'h0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_cnt <= 4'h0;
        end else if (take) begin
            ack_cnt <= 4'h0;
        end else if (mem_ack) begin
            ack_cnt <= ack_cnt + 4'h1;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_skip_end;
        done && !mem_req ##1 !base_writeback;
    endsequence
    a_skip_access: assert property (take && !exec |=> s_skip_end)
        else $error("skipped transfer touched memory or base");
    a_first_addr: assert property (take && exec |=>
        mem_req && mem_addr == $past(first_addr))
        else $error("first address wrong");
    a_addr_step: assert property (mem_req && mem_ack ##1 mem_req |->
        mem_addr == $past(mem_addr) + FPCTD_WORD_STEP)
        else $error("address step not one word");
    a_req_hold: assert property (mem_req && !mem_ack |=>
        $stable(mem_addr) && $stable(mem_wr))
        else $error("memory request changed before ack");
    a_ack_next: assert property (mem_req && !mem_ack |=> mem_ack)
        else $error("memory ack late");
    a_base_result: assert property (done |=> new_base == nb_q && base_writeback == wb_q)
        else $error("new base or write-back wrong");
    a_word_count: assert property (done |-> ack_cnt == nw_q)
        else $error("word count wrong");
    a_reject_flag: assert property (take && cond_pass && !cp_ok |=> done ##1 reject)
        else $error("bad coprocessor field not rejected");
    a_no_reject: assert property (done && nw_q != 4'h0 |=> !reject)
        else $error("executed transfer flagged as rejected");
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// testbench: both link ends driven over ahb-lite
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import fpctd_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [2:0]  dbg_idx = 3'h0;
    logic [31:0] hrdata, rd, ins, b;
    logic        hreadyout, hresp, c;
    logic [79:0] dbg_value;
    logic [31:0] w [0:11];
    int          n_errors = 0;
    int          checks = 0;
    int          cycles = 0;
    integer      seed = 2;
    always #5 hclk = ~hclk;
    fpctd_if i_fpctd_if (.hclk(hclk), .hresetn(hresetn));
    fpctd_device i_fpctd_device (.link(i_fpctd_if), .dbg_idx(dbg_idx), .dbg_value(dbg_value));
    fpctd_host #(.DEPTH(64)) i_fpctd_host (.link(i_fpctd_if), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    fpctd_assertions i_chk (.hclk(hclk), .hresetn(hresetn), .issue(i_fpctd_if.issue),
        .instr(i_fpctd_if.instr), .base(i_fpctd_if.base), .cond_pass(i_fpctd_if.cond_pass),
        .packed_format_flag(i_fpctd_if.packed_format_flag), .busy(i_fpctd_if.busy),
        .done(i_fpctd_if.done), .reject(i_fpctd_if.reject), .new_base(i_fpctd_if.new_base),
        .base_writeback(i_fpctd_if.base_writeback), .mem_req(i_fpctd_if.mem_req),
        .mem_wr(i_fpctd_if.mem_wr), .mem_addr(i_fpctd_if.mem_addr), .mem_ack(i_fpctd_if.mem_ack));
    ////////////////////////////////////////////////////////////////////////
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // polls status so the run never assumes a transfer length
    task automatic run(input logic [31:0] i, input logic [31:0] bs, input logic cp, input logic f);
        ahb(1'b1, FPCTD_REG_INSTR, i);
        ahb(1'b1, FPCTD_REG_BASE, bs);
        ahb(1'b1, FPCTD_REG_CTRL, {29'h0, f, cp, 1'b1});
        do ahb(1'b0, FPCTD_REG_STATUS, 32'h0);
        while (rd[1:0] !== 2'b10);
    endtask
    task automatic mput(input logic [7:0] idx, input logic [31:0] d);
        ahb(1'b1, FPCTD_REG_MADDR, {24'h0, idx});
        ahb(1'b1, FPCTD_REG_MDATA, d);
    endtask
    task automatic mget(input logic [7:0] idx);
        ahb(1'b1, FPCTD_REG_MADDR, {24'h0, idx});
        ahb(1'b0, FPCTD_REG_MDATA, 32'h0);
    endtask
    // f packs p, u, y, wb, l, x
    function automatic logic [31:0] mk(input logic [5:0] f, input logic [3:0] rn,
        input logic [2:0] fd, input logic [3:0] cp, input logic [7:0] off);
        return {4'hE, 3'b110, f[5:1], rn, f[0], fd, cp, off};
    endfunction
    function automatic logic [31:0] exp_base(input logic [31:0] i, input logic [31:0] bs);
        return i[23] ? bs + {22'h0, i[7:0], 2'b00} : bs - {22'h0, i[7:0], 2'b00};
    endfunction
    function automatic logic [2:0] exp_flags(input logic [31:0] i, input logic c);
        return {i[11:8] == 4'h1 && i[22] && i[15], c && i[11:8] != 4'h3 && i[21],
            c && i[11:8] == 4'h3};
    endfunction
    task automatic end_of_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            end_of_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int k = 0; k < 24; k++) begin
            ins = $random(seed);
            ins[31:25] = 7'h76;
            ins[19] = 1'b0;
            ins[11:8] = (k % 4 == 3) ? 4'h3 : {2'h0, k[1], ~k[1]};
            b = $random(seed);
            c = (k % 5 != 4);
            run(ins, b, c, k[2]);
            ahb(1'b0, FPCTD_REG_NBASE, 32'h0);
            chk({48'h0, rd}, {48'h0, (c && ins[11:8] != 4'h3) ? exp_base(ins, b) : b});
            ahb(1'b0, FPCTD_REG_STATUS, 32'h0);
            chk({77'h0, rd[4:2]}, {77'h0, exp_flags(ins, c)});
        end
        $display("test address done");
        mput(8'h08, 32'h3FF00000);
        mput(8'h09, 32'h30000000);
        run(mk(6'b110011, 4'h0, 3'h0, FPCTD_CP_SINGLE, 8'h00), 32'h20, 1'b1, 1'b0);
        run(mk(6'b110000, 4'h0, 3'h0, FPCTD_CP_SINGLE, 8'h00), 32'h40, 1'b1, 1'b0);
        mget(8'h10);
        chk({48'h0, rd}, {48'h0, 32'h3F800002});
        run(mk(6'b100001, 4'h0, 3'h0, FPCTD_CP_SINGLE, 8'h02), 32'h50, 1'b1, 1'b0);
        mget(8'h12);
        chk({48'h0, rd}, {48'h0, 32'h3FF00000});
        mget(8'h13);
        chk({48'h0, rd}, {48'h0, 32'h30000000});
        $display("test rounding done");
        for (int k = 0; k < 12; k++) begin
            w[k] = $random(seed);
            if (k % 3 == 0) w[k] = {w[k][31:16] | 16'h0001, 16'h0};
            if (k % 3 == 1) w[k][31] = 1'b1;
            mput(k[7:0], w[k]);
        end
        run(mk(6'b010010, 4'h0, 3'h6, FPCTD_CP_GROUP, 8'h00), 32'h0, 1'b1, 1'b0);
        for (int k = 0; k < 4; k++) begin
            dbg_idx <= k[2:0] + 3'h6;
            repeat (2) @(posedge hclk);
            chk(dbg_value, {w[3 * k][31:16], w[3 * k + 1], w[3 * k + 2]});
        end
        run(mk(6'b111100, 4'h1, 3'h7, FPCTD_CP_GROUP, 8'h20), 32'h0, 1'b1, 1'b0);
        for (int k = 0; k < 6; k++) begin
            mget(k[7:0] + 8'h20);
            chk({48'h0, rd}, {48'h0, w[k + 3]});
        end
        $display("test group done");
        end_of_test;
    end
endmodule
`default_nettype wire
